// ### core/nvs_pkg.sv
// shared constants and types for the shadowed register bank and otp map
package nvs_pkg;

  // ---------------------------------------------------------------
  // lane layout
  // ---------------------------------------------------------------
  localparam int NVS_DIES  = 2;
  localparam int NVS_LANES = 4;

  // ---------------------------------------------------------------
  // command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] NVS_OPC_RD_REG   = 8'h65;
  localparam logic [7:0] NVS_OPC_WR_REG   = 8'h71;
  localparam logic [7:0] NVS_OPC_OTP_PROG = 8'h42;
  localparam logic [7:0] NVS_OPC_OTP_READ = 8'h4B;
  localparam logic [7:0] NVS_OPC_SW_RESET = 8'hF0;
  localparam logic [2:0] NVS_ADDR_LAST_NIB = 3'h5;

  // ---------------------------------------------------------------
  // otp map
  // ---------------------------------------------------------------
  localparam int         NVS_OTP_AW        = 10;
  localparam int         NVS_OTP_BYTES     = 1024;
  localparam int         NVS_RAND_BYTES    = 16;
  localparam logic [9:0] NVS_OTP_LOCK_BASE = 10'h010;
  localparam logic [7:0] NVS_OTP_ERASED    = 8'hFF;

  // ---------------------------------------------------------------
  // register address map: low byte of address, bit 7 selects live
  // ---------------------------------------------------------------
  localparam int         NVS_REG_CNT      = 8;
  localparam int         NVS_REG_LIVE_BIT = 7;
  localparam logic [2:0] NVS_REG_STATUS_ONE  = 3'h0;
  localparam logic [2:0] NVS_REG_CONFIG_ONE  = 3'h1;
  localparam logic [2:0] NVS_REG_CONFIG_TWO  = 3'h2;
  localparam logic [2:0] NVS_REG_CONFIG_THR  = 3'h3;
  localparam logic [2:0] NVS_REG_CONFIG_FOUR = 3'h4;
  localparam logic [2:0] NVS_REG_DDR_TRAIN   = 3'h5;
  localparam logic [2:0] NVS_REG_PROT_LO     = 3'h6;
  localparam logic [2:0] NVS_REG_PROT_HI     = 3'h7;
  localparam int         NVS_FREEZE_BIT      = 0;

  typedef struct packed {
    logic [7:0] factory;
    logic [7:0] nv_mask;
    logic [7:0] live_mask;
    logic       is_otp;
  } nvs_reg_cfg_t;

  // factory value, persistent write mask, live write mask, otp kind
  localparam nvs_reg_cfg_t NVS_REG_CFG [NVS_REG_CNT] = '{
    '{8'h00, 8'h9C, 8'h1C, 1'b0},
    '{8'h00, 8'hFF, 8'hFF, 1'b0},
    '{8'h00, 8'hFF, 8'hFF, 1'b0},
    '{8'h00, 8'hFF, 8'hFF, 1'b0},
    '{8'h00, 8'hFF, 8'hFF, 1'b0},
    '{8'h00, 8'hFF, 8'hFF, 1'b0},
    '{8'hFF, 8'hFE, 8'h00, 1'b1},
    '{8'hFF, 8'hFF, 8'h00, 1'b1}
  };

  // ---------------------------------------------------------------
  // pin carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dat;
    logic [7:0] oe_n;
  } nvs_io_drv_t;

  typedef struct packed {
    logic [7:0]  opc;
    logic [23:0] addr;
  } nvs_frame_t;

endpackage

// ### core/nvs_reg_bank.sv
// dual-die shadowed register bank and otp space behind the lane pins
//
// What this block does
// - a register read returns the live copy when address bit 7 is set, the persistent copy otherwise.
// - a reset-pin or software reset reloads every live copy from its persistent copy; rst_n loads both copies with the factory value.
// - shadowed registers keep distinct persistent and live copies.
// - persistent writes update the persistent copy with the new contents.
// - otp programming programs persistent copy and updates live bits.
// - volatile writes change only live bits; persistent copy unchanged.
// - volatile bits reset to default; persistent/otp bits hold factory value.
// - otp bytes 000-00F hold factory random number, lsb lowest.
// - lock bytes 010-013, one bit per region; zero blocks programming.
// - otp bytes 014-01F reserved, erased on delivery.
// - regions 1-31 user space; all non-random bytes deliver as FF.
// - live freeze bit set refuses otp array programming until a volatile write or a reset reload clears it; otp-kind register writes are not blocked.
// - lanes 0-3 carry die zero nibbles, lanes 4-7 die one.
`timescale 1ns/100ps
`default_nettype none
module nvs_reg_bank
  import nvs_pkg::*;
#(
  parameter logic [127:0] RAND_DIE0 = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0,
  parameter logic [127:0] RAND_DIE1 = 128'h1032547698BADCFEEFCDAB8967452301
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        reset_pin_n,
  input  wire logic [7:0]  io_in,
  output nvs_io_drv_t      io_drv,
  output logic      [1:0]  otp_frozen
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic       s_sclk;
  logic       s_cs_n;
  logic       s_rst_pin_n;
  logic [7:0] s_io;
  logic       sclk_d_ff;
  logic       cs_n_d_ff;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       frame_end;

  if (NVS_OTP_BYTES != (1 << NVS_OTP_AW)) begin : g_chk
    $error("otp depth does not match its address width");
  end

  if (NVS_DIES * NVS_LANES != 8) begin : g_chk_lanes
    $error("lane groups do not cover the eight lane pins");
  end

  if (NVS_REG_CNT != (1 << 3)) begin : g_chk_regs
    $error("register index is three bits wide");
  end

  if (NVS_RAND_BYTES * 8 != $bits(RAND_DIE0)) begin : g_chk_rand
    $error("random number width does not match its byte count");
  end

  nvs_sync2 #(.W(3), .INIT(3'h7)) u_sync_ctl (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({sclk, cs_n, reset_pin_n}),
    .q     ({s_sclk, s_cs_n, s_rst_pin_n})
  );

  nvs_sync2 #(.W(8), .INIT(8'h00)) u_sync_io (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (io_in),
    .q     (s_io)
  );

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // idles high like the pin, so reset release makes no false rise
      sclk_d_ff <= 1'b1;
      cs_n_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= s_sclk;
      cs_n_d_ff <= s_cs_n;
    end
  end

  assign sclk_rise = s_sclk & ~sclk_d_ff & ~s_cs_n;
  assign sclk_fall = ~s_sclk & sclk_d_ff & ~s_cs_n;
  assign frame_end = s_cs_n & ~cs_n_d_ff;

  // ---------------------------------------------------------------
  // frame sequencer, shared by both dies
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DIN, ST_DOUT, ST_SKIP
  } nvs_state_t;

  nvs_state_t  state_ff;
  logic [2:0]  cnt_ff;
  logic        phase_ff;
  logic [3:0]  first_nib_ff [NVS_DIES];
  nvs_frame_t  frame_ff     [NVS_DIES];
  logic [3:0]  nib          [NVS_DIES];
  logic [7:0]  opc_now;
  logic        swrst_pulse;
  logic        byte_in_done;
  logic        is_reg_cmd;
  logic        hw_reload;

  // both dies share one sequencer; each lane group feeds its own die
  for (genvar d = 0; d < NVS_DIES; d++) begin : g_lane
    assign nib[d] = s_io[d*NVS_LANES +: NVS_LANES];
  end

  assign opc_now      = {first_nib_ff[0], nib[0]};
  assign swrst_pulse  = sclk_rise && (state_ff == ST_OPC) && phase_ff
                        && (opc_now == NVS_OPC_SW_RESET);
  assign byte_in_done = sclk_rise && (state_ff == ST_DIN) && phase_ff;
  assign is_reg_cmd   = (frame_ff[0].opc == NVS_OPC_RD_REG)
                        || (frame_ff[0].opc == NVS_OPC_WR_REG);
  // a held reset pin reloads the live copies on every cycle
  assign hw_reload    = ~s_rst_pin_n | swrst_pulse;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 3'h0;
      phase_ff <= 1'b0;
    end else if (frame_end || !s_rst_pin_n) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 3'h0;
      phase_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (!s_cs_n) begin
            state_ff <= ST_OPC;
            phase_ff <= 1'b0;
          end
        end
        ST_OPC: begin
          if (sclk_rise) begin
            phase_ff <= ~phase_ff;
            if (phase_ff) begin
              cnt_ff <= 3'h0;
              case (opc_now)
                NVS_OPC_RD_REG,
                NVS_OPC_WR_REG,
                NVS_OPC_OTP_PROG,
                NVS_OPC_OTP_READ: state_ff <= ST_ADDR;
                default:          state_ff <= ST_SKIP;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (sclk_rise) begin
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == NVS_ADDR_LAST_NIB) begin
              phase_ff <= 1'b0;
              if (frame_ff[0].opc == NVS_OPC_RD_REG
                  || frame_ff[0].opc == NVS_OPC_OTP_READ) begin
                state_ff <= ST_DOUT;
              end else begin
                state_ff <= ST_DIN;
              end
            end
          end
        end
        ST_DIN, ST_DOUT: begin
          if (sclk_rise) begin
            phase_ff <= ~phase_ff;
          end
        end
        ST_SKIP: begin
          // unknown opcode or software reset: sit out the rest of the frame
          state_ff <= ST_SKIP;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // per-die capture of opcode, address and data nibbles
  // ---------------------------------------------------------------
  logic [1:0] die_on;
  logic [7:0] wbyte [NVS_DIES];
  logic [7:0] rbyte [NVS_DIES];

  for (genvar d = 0; d < NVS_DIES; d++) begin : g_cap
    // a die whose own opcode differs from the sequencer's sits out
    assign die_on[d] = (frame_ff[d].opc == frame_ff[0].opc);
    assign wbyte[d]  = {first_nib_ff[d], nib[d]};

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        first_nib_ff[d] <= 4'h0;
        frame_ff[d]     <= '0;
      end else if (sclk_rise) begin
        if (!phase_ff) begin
          first_nib_ff[d] <= nib[d];
        end
        if (state_ff == ST_OPC && phase_ff) begin
          frame_ff[d].opc <= wbyte[d];
        end
        if (state_ff == ST_ADDR) begin
          frame_ff[d].addr <= {frame_ff[d].addr[19:0], nib[d]};
        end
        // otp streams walk the address; register streams repeat it
        if ((state_ff == ST_DIN || state_ff == ST_DOUT) && phase_ff
            && !is_reg_cmd) begin
          frame_ff[d].addr <= frame_ff[d].addr + 24'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // shadowed registers, one set per die
  // ---------------------------------------------------------------
  logic [7:0] nv_q   [NVS_DIES][NVS_REG_CNT];
  logic [7:0] live_q [NVS_DIES][NVS_REG_CNT];
  logic [2:0] reg_idx  [NVS_DIES];
  logic       reg_hit  [NVS_DIES];
  logic       reg_live [NVS_DIES];

  for (genvar d = 0; d < NVS_DIES; d++) begin : g_die
    assign reg_idx[d]  = frame_ff[d].addr[2:0];
    assign reg_live[d] = frame_ff[d].addr[NVS_REG_LIVE_BIT];
    assign reg_hit[d]  = (frame_ff[d].addr[23:8] == 16'h0000)
                         && (frame_ff[d].addr[6:3] == 4'h0);
    assign otp_frozen[d] = live_q[d][NVS_REG_CONFIG_ONE][NVS_FREEZE_BIT];

    for (genvar r = 0; r < NVS_REG_CNT; r++) begin : g_reg
      logic sel;
      assign sel = byte_in_done && die_on[d] && reg_hit[d]
                   && (frame_ff[d].opc == NVS_OPC_WR_REG)
                   && (reg_idx[d] == 3'(r));

      nvs_shadow_reg #(
        .FACTORY   (NVS_REG_CFG[r].factory),
        .NV_MASK   (NVS_REG_CFG[r].nv_mask),
        .LIVE_MASK (NVS_REG_CFG[r].live_mask),
        .IS_OTP    (NVS_REG_CFG[r].is_otp)
      ) u_reg (
        .clk     (clk),
        .rst_n   (rst_n),
        .reload  (hw_reload),
        .wr_nv   (sel && !reg_live[d]),
        .wr_live (sel && reg_live[d]),
        .wdata   (wbyte[d]),
        .nv_ff   (nv_q[d][r]),
        .live_ff (live_q[d][r])
      );
    end
  end

  // ---------------------------------------------------------------
  // otp space, one array per die
  // ---------------------------------------------------------------
  logic [7:0]  otp_mem [NVS_DIES][NVS_OTP_BYTES];
  logic [9:0]  otp_a   [NVS_DIES];
  logic [9:0]  lock_a  [NVS_DIES];
  logic [1:0]  otp_ok;

  for (genvar d = 0; d < NVS_DIES; d++) begin : g_otp
    assign otp_a[d]  = frame_ff[d].addr[9:0];
    // region n is guarded by bit n%8 of lock byte n/8
    assign lock_a[d] = NVS_OTP_LOCK_BASE + {8'h00, otp_a[d][9:8]};
    assign otp_ok[d] = byte_in_done && die_on[d]
                       && (frame_ff[d].opc == NVS_OPC_OTP_PROG)
                       && (frame_ff[d].addr[23:10] == 14'h0000)
                       && (otp_a[d] >= 10'(NVS_RAND_BYTES))
                       && !otp_frozen[d]
                       && otp_mem[d][lock_a[d]][otp_a[d][7:5]];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        for (int i = 0; i < NVS_OTP_BYTES; i++) begin
          if (i < NVS_RAND_BYTES) begin
            otp_mem[d][i] <= (d == 0) ? RAND_DIE0[i*8 +: 8]
                                      : RAND_DIE1[i*8 +: 8];
          end else begin
            otp_mem[d][i] <= NVS_OTP_ERASED;
          end
        end
      end else if (otp_ok[d]) begin
        otp_mem[d][otp_a[d]] <= otp_mem[d][otp_a[d]] & wbyte[d];
      end
    end
  end

  // ---------------------------------------------------------------
  // read path and pin drive
  // ---------------------------------------------------------------
  for (genvar d = 0; d < NVS_DIES; d++) begin : g_rd
    always_comb begin
      // unmapped registers and otp beyond the map read as zero
      rbyte[d] = 8'h00;
      if (frame_ff[d].opc == NVS_OPC_OTP_READ) begin
        if (frame_ff[d].addr[23:10] == 14'h0000) begin
          rbyte[d] = otp_mem[d][otp_a[d]];
        end
      end else if (reg_hit[d]) begin
        if (reg_live[d]) begin
          rbyte[d] = live_q[d][reg_idx[d]];
        end else begin
          rbyte[d] = nv_q[d][reg_idx[d]];
        end
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        io_drv.dat[d*NVS_LANES +: NVS_LANES]  <= 4'h0;
        io_drv.oe_n[d*NVS_LANES +: NVS_LANES] <= 4'hF;
      end else if (state_ff != ST_DOUT || s_cs_n || !die_on[d]) begin
        io_drv.oe_n[d*NVS_LANES +: NVS_LANES] <= 4'hF;
      end else if (sclk_fall) begin
        // high nibble first, matching the write direction
        io_drv.dat[d*NVS_LANES +: NVS_LANES] <=
          phase_ff ? rbyte[d][3:0] : rbyte[d][7:4];
        io_drv.oe_n[d*NVS_LANES +: NVS_LANES] <= 4'h0;
      end
    end
  end

endmodule
`default_nettype wire

// ### core/nvs_shadow_reg.sv
// one legacy register: persistent copy plus live copy
`timescale 1ns/100ps
`default_nettype none
module nvs_shadow_reg #(
  parameter logic [7:0] FACTORY   = 8'h00,
  parameter logic [7:0] NV_MASK   = 8'hFF,
  parameter logic [7:0] LIVE_MASK = 8'hFF,
  parameter bit         IS_OTP    = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reload,
  input  wire logic       wr_nv,
  input  wire logic       wr_live,
  input  wire logic [7:0] wdata,
  output logic      [7:0] nv_ff,
  output logic      [7:0] live_ff
);
  logic [7:0] nxt_prog;

  // otp cells only ever lose ones
  assign nxt_prog = nv_ff & (wdata | ~NV_MASK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_ff <= FACTORY;
    end else if (wr_nv) begin
      if (IS_OTP) begin
        nv_ff <= nxt_prog;
      end else begin
        nv_ff <= (nv_ff & ~NV_MASK) | (wdata & NV_MASK);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_ff <= FACTORY;
    end else if (reload) begin
      live_ff <= nv_ff;
    end else if (wr_nv && IS_OTP) begin
      live_ff <= live_ff & (wdata | ~NV_MASK);
    end else if (wr_live) begin
      live_ff <= (live_ff & ~LIVE_MASK) | (wdata & LIVE_MASK);
    end
  end
endmodule
`default_nettype wire

// ### core/nvs_sync2.sv
// two-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module nvs_sync2 #(
  parameter int            W     = 1,
  parameter logic [W-1:0]  INIT  = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  if (W < 1) begin : g_chk
    $error("nvs_sync2 width must be at least one");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= INIT;
      q       <= INIT;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ### verif/nvs_host.sv
// host flash controller model driving both lane groups
`timescale 1ns/100ps
`default_nettype none
module nvs_host (
  input  wire logic       clk,
  input  wire logic [7:0] io_lvl,
  output logic            sclk,
  output logic            cs_n,
  output logic      [7:0] host_io
);
  // idle: clock and select stand high between frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    host_io = 8'h00;
  end

  // released lanes show the inverse, never a kind stale value
  task automatic nib(input logic [7:0] v, input logic drv,
                     output logic [7:0] r);
    @(negedge clk);
    sclk = 1'b0;
    host_io = drv ? v : ~host_io;
    repeat (6) @(negedge clk);
    r = io_lvl;
    sclk = 1'b1;
    repeat (5) @(negedge clk);
  endtask

  task automatic byte2(input logic [7:0] d0, input logic [7:0] d1,
                       input logic drv, output logic [15:0] r);
    logic [7:0] h;
    logic [7:0] l;
    nib({d1[7:4], d0[7:4]}, drv, h);
    nib({d1[3:0], d0[3:0]}, drv, l);
    r = {h[7:4], l[7:4], h[3:0], l[3:0]};
  endtask

  // mode 0 write byte, 1 read byte, 2 opcode only
  task automatic access(input logic [7:0] opc, input logic [23:0] a,
                        input logic [15:0] wd, input int mode,
                        output logic [15:0] rd);
    logic [15:0] dummy;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    byte2(opc, opc, 1'b1, dummy);
    if (mode != 2) begin
      for (int i = 2; i >= 0; i--) begin
        byte2(a[8*i+:8], a[8*i+:8], 1'b1, dummy);
      end
    end
    rd = 16'h0000;
    if (mode == 0) byte2(wd[7:0], wd[15:8], 1'b1, dummy);
    if (mode == 1) byte2(8'h00, 8'h00, 1'b0, rd);
    @(negedge clk);
    cs_n = 1'b1;
    repeat (14) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### verif/nvs_reg_bank_bench.sv
// self-checking bench for the shadowed register bank and otp map
`timescale 1ns/100ps
`default_nettype none
module nvs_reg_bank_bench;
  import nvs_pkg::*;
  // random numbers are arbitrary
  localparam logic [127:0] RND0 = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] RND1 = 128'h0123456789ABCDEFFEDCBA9876543210;
  logic        clk;
  logic        rst_n;
  logic        reset_pin_n;
  logic        sclk;
  logic        cs_n;
  logic [7:0]  io_in;
  logic [7:0]  host_io;
  logic [1:0]  otp_frozen;
  nvs_io_drv_t io_drv;
  logic [15:0] rd;
  int          n_mismatch;
  int          n_checks;

  assign io_in = (io_drv.dat & ~io_drv.oe_n) | (host_io & io_drv.oe_n);

  nvs_reg_bank #(.RAND_DIE0(RND0), .RAND_DIE1(RND1)) dut (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .reset_pin_n(reset_pin_n), .io_in(io_in), .io_drv(io_drv),
    .otp_frozen(otp_frozen));
  nvs_host u_host (.clk(clk), .io_lvl(io_in), .sclk(sclk),
    .cs_n(cs_n), .host_io(host_io));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [23:0] ra(input logic lv, input logic [2:0] i);
    return {16'h0000, lv, 4'h0, i};
  endfunction
  task automatic wr(input logic [7:0] opc, input logic [23:0] a,
                    input logic [15:0] d);
    u_host.access(opc, a, d, 0, rd);
  endtask
  task automatic rchk(input logic [7:0] opc, input logic [23:0] a,
                      input logic [15:0] exp);
    u_host.access(opc, a, 16'h0000, 1, rd);
    chk(rd, exp);
  endtask
  task automatic pin_reset();
    @(negedge clk);
    reset_pin_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_pin_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults();
    logic [15:0] f;
    for (int i = 0; i < NVS_REG_CNT; i++) begin
      f = {2{NVS_REG_CFG[i].factory}};
      rchk(NVS_OPC_RD_REG, ra(1'b1, 3'(i)), f);
      rchk(NVS_OPC_RD_REG, ra(1'b0, 3'(i)), f);
    end
    rchk(NVS_OPC_RD_REG, 24'h000008, 16'h0000);
  endtask
  task automatic t_shadow();
    wr(NVS_OPC_WR_REG, ra(1'b1, 3'h2), 16'hA55A);
    rchk(NVS_OPC_RD_REG, ra(1'b1, 3'h2), 16'hA55A);
    rchk(NVS_OPC_RD_REG, ra(1'b0, 3'h2), 16'h0000);
    wr(NVS_OPC_WR_REG, ra(1'b0, 3'h3), 16'h3CC3);
    rchk(NVS_OPC_RD_REG, ra(1'b0, 3'h3), 16'h3CC3);
    rchk(NVS_OPC_RD_REG, ra(1'b1, 3'h3), 16'h0000);
    wr(NVS_OPC_WR_REG, ra(1'b1, 3'h0), 16'hFFFF);
    rchk(NVS_OPC_RD_REG, ra(1'b1, 3'h0), {2{NVS_REG_CFG[0].live_mask}});
    wr(NVS_OPC_WR_REG, ra(1'b0, 3'h0), 16'hFFFF);
    rchk(NVS_OPC_RD_REG, ra(1'b0, 3'h0), {2{NVS_REG_CFG[0].nv_mask}});
  endtask
  task automatic t_reload();
    pin_reset();
    rchk(NVS_OPC_RD_REG, ra(1'b1, 3'h2), 16'h0000);
    rchk(NVS_OPC_RD_REG, ra(1'b1, 3'h3), 16'h3CC3);
    rchk(NVS_OPC_RD_REG, ra(1'b1, 3'h0), {2{NVS_REG_CFG[0].nv_mask}});
    wr(NVS_OPC_WR_REG, ra(1'b1, 3'h2), 16'h1111);
    u_host.access(NVS_OPC_SW_RESET, 24'h0, 16'h0, 2, rd);
    rchk(NVS_OPC_RD_REG, ra(1'b1, 3'h2), 16'h0000);
  endtask
  task automatic t_otp();
    logic [7:0] p;
    rchk(NVS_OPC_OTP_READ, 24'h000, {RND1[7:0], RND0[7:0]});
    rchk(NVS_OPC_OTP_READ, 24'h00F, {RND1[127:120], RND0[127:120]});
    rchk(NVS_OPC_OTP_READ, 24'h014, 16'hFFFF);
    rchk(NVS_OPC_OTP_READ, 24'h3FF, 16'hFFFF);
    wr(NVS_OPC_OTP_PROG, 24'h000, 16'h0000);
    rchk(NVS_OPC_OTP_READ, 24'h000, {RND1[7:0], RND0[7:0]});
    wr(NVS_OPC_OTP_PROG, 24'h020, 16'h5AA5);
    rchk(NVS_OPC_OTP_READ, 24'h020, 16'h5AA5);
    wr(NVS_OPC_OTP_PROG, 24'h020, 16'hFFFF);
    wr(NVS_OPC_OTP_PROG, 24'h020, 16'h0F0F);
    rchk(NVS_OPC_OTP_READ, 24'h020, 16'h0A05);
    wr(NVS_OPC_OTP_PROG, 24'h010, 16'hFDFD);
    rchk(NVS_OPC_OTP_READ, 24'h010, 16'hFDFD);
    wr(NVS_OPC_OTP_PROG, 24'h021, 16'h0000);
    rchk(NVS_OPC_OTP_READ, 24'h021, 16'hFFFF);
    p = 8'hF0 | ~NVS_REG_CFG[6].nv_mask;
    wr(NVS_OPC_WR_REG, ra(1'b0, 3'h6), 16'hF0F0);
    rchk(NVS_OPC_RD_REG, ra(1'b0, 3'h6), {p, p});
    rchk(NVS_OPC_RD_REG, ra(1'b1, 3'h6), {p, p});
    wr(NVS_OPC_WR_REG, ra(1'b0, 3'h6), 16'hFFFF);
    rchk(NVS_OPC_RD_REG, ra(1'b0, 3'h6), {p, p});
  endtask
  task automatic t_freeze();
    wr(NVS_OPC_WR_REG, ra(1'b1, 3'h1), 16'h0101);
    chk({14'h0000, otp_frozen}, 16'h0003);
    wr(NVS_OPC_OTP_PROG, 24'h040, 16'h0000);
    rchk(NVS_OPC_OTP_READ, 24'h040, 16'hFFFF);
    pin_reset();
    chk({14'h0000, otp_frozen}, 16'h0000);
    wr(NVS_OPC_OTP_PROG, 24'h040, 16'h0000);
    rchk(NVS_OPC_OTP_READ, 24'h040, 16'h0000);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rst_n = 1'b0;
    reset_pin_n = 1'b1;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_defaults();
    t_shadow();
    t_reload();
    t_otp();
    t_freeze();
    final_report();
  end
  // about 60 frames of some 140 clocks each, with ample margin
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire

// ### verif/nvs_reg_bank_props.sv
// concurrent checks on the shadowed register bank pins
`timescale 1ns/100ps
`default_nettype none
module nvs_reg_bank_props
  import nvs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        reset_pin_n,
  input wire logic [7:0]  io_in,
  input wire nvs_io_drv_t io_drv,
  input wire logic [1:0]  otp_frozen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence rise_in_frame;
    $rose(sclk) && !cs_n;
  endsequence
  sequence pin_reset_recent;
    !$past(reset_pin_n, 3) || !$past(reset_pin_n, 4) ||
      !$past(reset_pin_n, 5);
  endsequence

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  idle_oe_high_a: assert property (cs_n [*5] |-> io_drv.oe_n == 8'hFF)
    else $error("lanes driven outside a frame");
  lane_group_oe_a: assert property (
    io_drv.oe_n[3:0] == {4{io_drv.oe_n[0]}} &&
    io_drv.oe_n[7:4] == {4{io_drv.oe_n[4]}})
    else $error("lane group enables split");
  reset_quiet_a: assert property ($rose(rst_n) |->
    io_drv.oe_n == 8'hFF && io_drv.dat == 8'h00 && otp_frozen == 2'b00)
    else $error("outputs not quiet at reset release");
  hw_reset_clear_a: assert property (
    !reset_pin_n [*6] |-> otp_frozen == 2'b00)
    else $error("freeze bit survives reset pin");
  freeze_in_frame_a: assert property (
    $rose(otp_frozen[0]) || $rose(otp_frozen[1]) |-> !$past(cs_n))
    else $error("freeze bit set outside a frame");
  unfreeze_cause_a: assert property ($fell(otp_frozen[0]) |->
    !$past(cs_n) or pin_reset_recent)
    else $error("freeze bit cleared without reset");
  drive_in_frame_a: assert property (
    io_drv.oe_n != 8'hFF |-> !$past(cs_n, 5))
    else $error("lanes driven without chip select");
  read_hold_a: assert property (
    rise_in_frame |-> $stable(io_drv.dat) [*6])
    else $error("read nibble changed while clock high");
endmodule

bind nvs_reg_bank nvs_reg_bank_props u_props (
  .clk         (clk),
  .rst_n       (rst_n),
  .sclk        (sclk),
  .cs_n        (cs_n),
  .reset_pin_n (reset_pin_n),
  .io_in       (io_in),
  .io_drv      (io_drv),
  .otp_frozen  (otp_frozen)
);
`default_nettype wire
